// ===== logic/mgm_mask_top.sv
// Purpose: Gate output mask stage of a three-phase motor controller
// Assumes: Hall decoder commands and PWM come in on hclk
// Notes: Gate outputs are registered, one cycle after their cause
//
// The AHB-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
module mgm_mask_top (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Hall decoder commands
  input wire logic cmd_a_high,
  input wire logic cmd_a_low,
  input wire logic cmd_b_high,
  input wire logic cmd_b_low,
  input wire logic cmd_c_high,
  input wire logic cmd_c_low,
  // PWM generator
  input wire logic pwm_true,
  input wire logic pwm_inverted,
  // Filtered Hall levels
  input wire logic filtered_hall_a,
  input wire logic filtered_hall_b,
  input wire logic filtered_hall_c,
  // Gate drive outputs
  output logic out_a_high,
  output logic out_a_low,
  output logic out_b_high,
  output logic out_b_low,
  output logic out_c_high,
  output logic out_c_low
);
  ////////////////////////////////////////////////////////////////////////
  // State and wiring
  typedef struct packed {
    logic mask_mode_select;
    logic noncomplementary_select;
    logic freerun_brake_select;
    logic pwm_side_select;
    logic brake_enable;
    logic protect;
    logic [5:0] mask_enable_reg;
    logic [5:0] mask_data_reg;
    logic [2:0] gpio_sel;
    logic [5:0] gate;
  } mgm_state_t;

  mgm_state_t st;
  mgm_state_t next_st;
  mgm_pkg::mgm_mode_t mode;
  mgm_reg_if rif ();
  logic [2:0] cmd_hi;
  logic [2:0] cmd_lo;
  logic [1:0] hw_pair [3];
  logic [1:0] comp_pair [3];
  logic [2:0] pwm_act;
  logic [2:0] hall;
  logic unused_size;

  assign cmd_hi = {cmd_c_high, cmd_b_high, cmd_a_high};
  assign cmd_lo = {cmd_c_low, cmd_b_low, cmd_a_low};
  assign hall = {filtered_hall_c, filtered_hall_b, filtered_hall_a};
  // Only word transfers occur; size is not decoded
  assign unused_size = ^hsize;

  ////////////////////////////////////////////////////////////////////////
  // Bus slave and per-phase decoders
  mgm_ahb_slave u_slave (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .rif(rif.slave)
  );

  for (genvar p = 0; p < 3; p++) begin : g_phase
    mgm_phase_decode u_dec (
      .cmd_high(cmd_hi[p]),
      .cmd_low(cmd_lo[p]),
      .pwm_true(pwm_true),
      .pwm_inverted(pwm_inverted),
      .pwm_side_select(st.pwm_side_select),
      .noncomplementary_select(st.noncomplementary_select),
      .hw_pair(hw_pair[p]),
      .comp_pair(comp_pair[p]),
      .pwm_active(pwm_act[p])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Software mask of one pair, bit 0 high side, bit 1 low side
  function automatic logic [1:0] sw_pair(input logic [1:0] gen,
      input logic [1:0] me, input logic [1:0] md, input logic act);
    logic [1:0] o;
    o = (me & md) | (~me & gen);
    // Both masked high would short the pair
    if (&me && &md) begin
      o = 2'h0;
    end
    // The unmasked partner carries PWM, so no masked high
    if (act && (me[0] ^ me[1])) begin
      o = o & ~me;
    end
    return o;
  endfunction : sw_pair

  ////////////////////////////////////////////////////////////////////////
  // Mode decode; brake first, then protection
  always_comb begin
    if (st.brake_enable) begin
      mode = mgm_pkg::MGM_MODE_BRAKE;
    end else if (st.protect) begin
      mode = mgm_pkg::MGM_MODE_PROT;
    end else if (st.mask_mode_select) begin
      mode = mgm_pkg::MGM_MODE_SW;
    end else begin
      mode = mgm_pkg::MGM_MODE_HW;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read mux
  always_comb begin
    rif.rdata = 8'h00;
    unique case (rif.rd_idx)
      3'(mgm_pkg::OFS_CTRL >> 2): begin
        rif.rdata[mgm_pkg::CTRL_MASK_MODE] = st.mask_mode_select;
        rif.rdata[mgm_pkg::CTRL_NONCOMP] = st.noncomplementary_select;
        rif.rdata[mgm_pkg::CTRL_FREERUN] = st.freerun_brake_select;
        rif.rdata[mgm_pkg::CTRL_SIDE] = st.pwm_side_select;
      end
      3'(mgm_pkg::OFS_PROT >> 2): begin
        rif.rdata[mgm_pkg::PROT_BRAKE] = st.brake_enable;
        rif.rdata[mgm_pkg::PROT_PROTECT] = st.protect;
      end
      3'(mgm_pkg::OFS_STATUS >> 2): begin
        rif.rdata[mgm_pkg::STAT_GATE_LSB +: 3] =
          {st.gate[0], st.gate[1], st.gate[2]};
        rif.rdata[mgm_pkg::STAT_HALL_LSB +: 3] = hall;
      end
      3'(mgm_pkg::OFS_MASK_EN >> 2): rif.rdata = {2'h0, st.mask_enable_reg};
      3'(mgm_pkg::OFS_MASK_DATA >> 2): rif.rdata = {2'h0, st.mask_data_reg};
      3'(mgm_pkg::OFS_GPIO_SEL >> 2): rif.rdata = {5'h0, st.gpio_sel};
      default: rif.rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state: register writes and gate outputs
  always_comb begin
    logic [5:0] g;
    logic [1:0] pr;
    g = mgm_pkg::GATES_OFF;
    pr = 2'h0;
    next_st = st;
    if (rif.wr_en) begin
      unique case (rif.wr_idx)
        3'(mgm_pkg::OFS_CTRL >> 2): begin
          next_st.mask_mode_select = rif.wdata[mgm_pkg::CTRL_MASK_MODE];
          next_st.noncomplementary_select =
            rif.wdata[mgm_pkg::CTRL_NONCOMP];
          next_st.freerun_brake_select = rif.wdata[mgm_pkg::CTRL_FREERUN];
          next_st.pwm_side_select = rif.wdata[mgm_pkg::CTRL_SIDE];
        end
        3'(mgm_pkg::OFS_PROT >> 2): begin
          next_st.brake_enable = rif.wdata[mgm_pkg::PROT_BRAKE];
          next_st.protect = rif.wdata[mgm_pkg::PROT_PROTECT];
        end
        3'(mgm_pkg::OFS_MASK_EN >> 2):
          next_st.mask_enable_reg = rif.wdata[5:0];
        3'(mgm_pkg::OFS_MASK_DATA >> 2):
          next_st.mask_data_reg = rif.wdata[5:0];
        3'(mgm_pkg::OFS_GPIO_SEL >> 2): next_st.gpio_sel = rif.wdata[2:0];
        default: next_st.gpio_sel = st.gpio_sel;
      endcase
    end
    unique case (mode)
      mgm_pkg::MGM_MODE_BRAKE: g = mgm_pkg::GATES_BRAKE;
      mgm_pkg::MGM_MODE_PROT: begin
        g = st.freerun_brake_select ? mgm_pkg::GATES_BRAKE
          : mgm_pkg::GATES_OFF;
      end
      mgm_pkg::MGM_MODE_SW: begin
        for (int p = 0; p < 3; p++) begin
          pr = sw_pair(comp_pair[p], st.mask_enable_reg[2*p +: 2],
            st.mask_data_reg[2*p +: 2], pwm_act[p]);
          g[2*p +: 2] = pr;
        end
      end
      default: begin
        for (int p = 0; p < 3; p++) begin
          g[2*p +: 2] = hw_pair[p];
        end
      end
    endcase
    // Phases handed to general I/O leave the gate lines idle
    for (int p = 0; p < 3; p++) begin
      if (st.gpio_sel[p]) begin
        g[2*p +: 2] = 2'h0;
      end
    end
    next_st.gate = g;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign out_a_high = st.gate[0];
  assign out_a_low = st.gate[1];
  assign out_b_high = st.gate[2];
  assign out_b_low = st.gate[3];
  assign out_c_high = st.gate[4];
  assign out_c_low = st.gate[5];

  ////////////////////////////////////////////////////////////////////////
  // Checks on the registered gate outputs
  a_brake_gates: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && st.brake_enable && st.gpio_sel == 3'h0
    |=> {out_c_low, out_c_high, out_b_low, out_b_high, out_a_low,
      out_a_high} == 6'h2a)
    else $error("brake pattern wrong");

  a_protect_free: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && !st.brake_enable && st.protect && !st.freerun_brake_select
    |=> st.gate == 6'h00)
    else $error("free-run protection not all off");

  a_protect_brake: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && !st.brake_enable && st.protect && st.freerun_brake_select
      && !st.gpio_sel[0]
    |=> !out_a_high && out_a_low)
    else $error("protection brake state wrong");

  a_hw_comp_low: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && mode == mgm_pkg::MGM_MODE_HW && !st.gpio_sel[0]
      && !st.pwm_side_select && !st.noncomplementary_select
      && !cmd_a_high && cmd_a_low
    |=> out_a_high == $past(pwm_inverted) && out_a_low == $past(pwm_true))
    else $error("complementary low side decode wrong");

  a_hw_noncomp_high: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && mode == mgm_pkg::MGM_MODE_HW && !st.gpio_sel[1]
      && st.pwm_side_select && st.noncomplementary_select
      && cmd_b_high && !cmd_b_low
    |=> out_b_high == $past(pwm_true) && !out_b_low)
    else $error("non-complementary high side decode wrong");

  a_sw_mask_data: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && mode == mgm_pkg::MGM_MODE_SW && !st.gpio_sel[2]
      && st.mask_enable_reg[5:4] == 2'h3 && st.mask_data_reg[5:4] == 2'h2
    |=> out_c_low && !out_c_high)
    else $error("mask data not driven");

  a_pair_both_high: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && mode == mgm_pkg::MGM_MODE_SW
      && st.mask_enable_reg[1:0] == 2'h3 && st.mask_data_reg[1:0] == 2'h3
    |=> !out_a_high && !out_a_low)
    else $error("fully masked pair not forced low");

  a_gpio_quiet: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && st.gpio_sel[1] |=> !out_b_high && !out_b_low)
    else $error("I/O phase gates not idle");

  a_status_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rif.rd_idx == 3'(mgm_pkg::OFS_STATUS >> 2)
    |-> rif.rdata[5:3] == {out_a_high, out_a_low, out_b_high})
    else $error("status gate bits disagree with outputs");

  a_freeze_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !ce ##1 !ce |-> $stable(st.gate))
    else $error("gates moved while frozen");
endmodule : mgm_mask_top

// ===== logic/mgm_pkg.sv
// Purpose: Shared constants for the motor gate mask block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: Gate vector bit 2p is phase p high side, 2p+1 its low side
package mgm_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PROT = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK_EN = 8'h0c;
  localparam logic [7:0] OFS_MASK_DATA = 8'h10;
  localparam logic [7:0] OFS_GPIO_SEL = 8'h14;
  localparam int IDX_W = 3;
  localparam logic [IDX_W-1:0] IDX_LAST = 3'h5;
  // Control register fields
  localparam int CTRL_MASK_MODE = 7;
  localparam int CTRL_NONCOMP = 3;
  localparam int CTRL_FREERUN = 1;
  localparam int CTRL_SIDE = 0;
  // Brake and protection register fields
  localparam int PROT_BRAKE = 0;
  localparam int PROT_PROTECT = 1;
  // Status register fields
  localparam int STAT_GATE_LSB = 3;
  localparam int STAT_HALL_LSB = 0;
  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [1:0] RST_PROT = 2'h0;
  localparam logic [5:0] RST_MASK = 6'h00;
  localparam logic [2:0] RST_GPIO = 3'h0;
  localparam logic [5:0] RST_GATES = 6'h00;
  // Fixed gate patterns
  localparam logic [5:0] GATES_BRAKE = 6'h2a;
  localparam logic [5:0] GATES_OFF = 6'h00;
  // Decoded operating mode, one-hot
  typedef enum logic [3:0] {
    MGM_MODE_HW = 4'h1,
    MGM_MODE_SW = 4'h2,
    MGM_MODE_PROT = 4'h4,
    MGM_MODE_BRAKE = 4'h8
  } mgm_mode_t;
endpackage : mgm_pkg

// ===== logic/mgm_reg_if.sv
// Purpose: Register access carrier between bus slave and mask core
// Assumes: Single clock domain
// Notes: Read data is sampled by the slave in the address phase
`timescale 1ns/1ns
interface mgm_reg_if;
  logic wr_en;
  logic [mgm_pkg::IDX_W-1:0] wr_idx;
  logic [7:0] wdata;
  logic [mgm_pkg::IDX_W-1:0] rd_idx;
  logic [7:0] rdata;
  modport slave (output wr_en, wr_idx, wdata, rd_idx, input rdata);
  modport regs (input wr_en, wr_idx, wdata, rd_idx, output rdata);
endinterface : mgm_reg_if

// ===== logic/mgm_ahb_slave.sv
// Purpose: AHB-Lite slave front end for the mask registers
// Assumes: Word transfers only; response always OKAY
// Notes: Zero wait states while the clock enable is high
`timescale 1ns/1ns
module mgm_ahb_slave (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Register side
  mgm_reg_if.slave rif
);
  typedef struct packed {
    logic dwrite;
    logic [mgm_pkg::IDX_W-1:0] didx;
    logic [31:0] rdata;
  } mgm_slv_t;
  mgm_slv_t st;
  mgm_slv_t next_st;
  logic take;
  logic mapped;

  assign take = hsel && htrans[1] && hready && ce;
  assign mapped = (haddr[31:5] == 27'h0) && (haddr[1:0] == 2'h0)
    && (haddr[4:2] <= mgm_pkg::IDX_LAST);
  assign rif.rd_idx = haddr[4:2];
  // Stretch the data phase while the block is frozen
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = st.rdata;
  assign rif.wr_en = st.dwrite && ce;
  assign rif.wr_idx = st.didx;
  assign rif.wdata = hwdata[7:0];

  always_comb begin
    next_st = st;
    if (take) begin
      next_st.dwrite = hwrite && mapped;
      next_st.didx = haddr[4:2];
      // Unmapped reads return zero
      next_st.rdata = (!hwrite && mapped) ? {24'h0, rif.rdata} : 32'h0;
    end else if (ce) begin
      next_st.dwrite = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end
endmodule : mgm_ahb_slave

// ===== logic/mgm_phase_decode.sv
// Purpose: Hardware mask decode of one phase's high/low command
// Assumes: Commands and PWM are synchronous to the system clock
// Notes: Purely combinational; the core registers the result
`timescale 1ns/1ns
module mgm_phase_decode (
  // Commands
  input wire logic cmd_high,
  input wire logic cmd_low,
  input wire logic pwm_true,
  input wire logic pwm_inverted,
  input wire logic pwm_side_select,
  input wire logic noncomplementary_select,
  // Results, bit 0 high side, bit 1 low side
  output logic [1:0] hw_pair,
  output logic [1:0] comp_pair,
  output logic pwm_active
);
  function automatic logic [1:0] decode(input logic [1:0] cmd,
      input logic side, input logic noncomp, input logic pt,
      input logic pi);
    logic [1:0] r;
    r = 2'h0;
    unique case (cmd)
      2'h1: r = side ? 2'h2 : {pt, noncomp ? 1'b0 : pi};
      2'h2: r = side ? {noncomp ? 1'b0 : pi, pt} : 2'h1;
      default: r = 2'h0;
    endcase
    return r;
  endfunction : decode

  assign hw_pair = decode({cmd_high, cmd_low}, pwm_side_select,
    noncomplementary_select, pwm_true, pwm_inverted);
  assign comp_pair = decode({cmd_high, cmd_low}, pwm_side_select,
    1'b0, pwm_true, pwm_inverted);
  assign pwm_active = pwm_side_select ? (cmd_high && !cmd_low)
    : (!cmd_high && cmd_low);
endmodule : mgm_phase_decode

// ===== test/mgm_gate_drv_model.sv
// Purpose: Behavioural stand-in for the three external transistor pairs
// Assumes: Gate level 1 switches a transistor on
// Notes: Counts strobed clock edges on which a pair conducts on both sides
`timescale 1ns/1ns
module mgm_gate_drv_model (
  // Clock
  input wire logic hclk,
  // Gate drive, bit 2p high side of phase p, bit 2p+1 its low side
  input wire logic [5:0] gates,
  // Sample strobe from the bench
  input wire logic look,
  // Observation
  output int shorts
);
  int count = 0;
  assign shorts = count;
  // A pair on at both sides would short the supply rail. Masking one side
  // on while commutation drives the other is legal, so the bench predicts
  // the count rather than expecting none.
  always @(posedge hclk) begin
    if (look && ((gates[0] & gates[1]) | (gates[2] & gates[3]) |
        (gates[4] & gates[5]))) begin
      count <= count + 1;
    end
  end
endmodule : mgm_gate_drv_model

// ===== test/tb_top.sv
// Purpose: Self-checking bench for the motor gate mask block
// Assumes: Single AHB-Lite master, clock enable low only in the freeze test
// Notes: Expected gates come from a behavioural model of the mask rules
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
  num_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp;
  logic [31:0] hrdata;
  logic [5:0] cmd = 6'h00;
  logic pt = 1'b0;
  logic pi = 1'b1;
  logic [2:0] hall = 3'h6;
  logic [5:0] gates;
  logic [7:0] ctrl = 8'h00;
  logic [1:0] prot = 2'h0;
  logic [5:0] me = 6'h00;
  logic [5:0] md = 6'h00;
  logic [2:0] gpio = 3'h0;
  int shorts;
  int num_errors = 0;
  int checks = 0;
  int exp_shorts = 0;
  logic ce = 1'b1;
  logic look = 1'b0;
  always #25 hclk = ~hclk;
  assign hready = hreadyout;
  mgm_mask_top i_dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp),
    .cmd_a_high(cmd[0]), .cmd_a_low(cmd[1]), .cmd_b_high(cmd[2]),
    .cmd_b_low(cmd[3]), .cmd_c_high(cmd[4]), .cmd_c_low(cmd[5]),
    .pwm_true(pt), .pwm_inverted(pi), .filtered_hall_a(hall[0]),
    .filtered_hall_b(hall[1]), .filtered_hall_c(hall[2]),
    .out_a_high(gates[0]), .out_a_low(gates[1]), .out_b_high(gates[2]),
    .out_b_low(gates[3]), .out_c_high(gates[4]), .out_c_low(gates[5])
  );
  mgm_gate_drv_model i_drv (.hclk(hclk), .gates(gates), .look(look),
    .shorts(shorts));
  //////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      num_errors++;
      report_and_stop();
    end
  endtask : wait_ready
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] ex);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    `CHK(nm, ex, r)
  endtask : rd_chk
  task automatic cfg();
    wr(mgm_pkg::OFS_CTRL, {24'h0, ctrl});
    wr(mgm_pkg::OFS_PROT, {30'h0, prot});
    wr(mgm_pkg::OFS_MASK_EN, {26'h0, me});
    wr(mgm_pkg::OFS_MASK_DATA, {26'h0, md});
    wr(mgm_pkg::OFS_GPIO_SEL, {29'h0, gpio});
  endtask : cfg
  //////////////////////////////////////////////////////////////////////////
  // Pair codes below are {high, low}
  function automatic logic [5:0] exp_gates();
    logic [5:0] e;
    logic [1:0] c, cp, nc, m, d;
    logic act;
    e = 6'h00;
    for (int p = 0; p < 3; p++) begin
      c = {cmd[2*p], cmd[2*p+1]};
      m = {me[2*p], me[2*p+1]};
      d = {md[2*p], md[2*p+1]};
      cp = 2'h0;
      nc = 2'h0;
      if (c == 2'h1) begin
        cp = ctrl[0] ? 2'h1 : {pi, pt};
        nc = ctrl[0] ? 2'h1 : {1'b0, pt};
      end
      if (c == 2'h2) begin
        cp = ctrl[0] ? {pt, pi} : 2'h2;
        nc = ctrl[0] ? {pt, 1'b0} : 2'h2;
      end
      act = ctrl[0] ? (c == 2'h2) : (c == 2'h1);
      if (!ctrl[7]) begin
        cp = ctrl[3] ? nc : cp;
      end else begin
        cp = (m & d) | (~m & cp);
        if (m == 2'h3 && d == 2'h3) cp = 2'h0;
        // Partner of the PWM channel may only be masked low
        if (act && ^m) cp = cp & ~m;
      end
      if (prot[1]) cp = {1'b0, ctrl[1]};
      if (prot[0]) cp = 2'h1;
      // Pins on general I/O are not gates, whatever the mode
      if (gpio[p]) cp = 2'h0;
      e[2*p] = cp[1];
      e[2*p+1] = cp[0];
    end
    return e;
  endfunction : exp_gates
  task automatic gate_chk(input string nm);
    logic [5:0] e;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    e = exp_gates();
    `CHK(nm, e, gates)
    if ((e[0] & e[1]) | (e[2] & e[3]) | (e[4] & e[5])) exp_shorts++;
    // Let the partner sample this settled pattern once
    look <= 1'b1;
    @(posedge hclk);
    look <= 1'b0;
  endtask : gate_chk
  //////////////////////////////////////////////////////////////////////////
  initial begin
    logic [5:0] e;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("ctrl", mgm_pkg::OFS_CTRL, 32'h0);
    rd_chk("prot", mgm_pkg::OFS_PROT, 32'h0);
    rd_chk("mask_en", mgm_pkg::OFS_MASK_EN, 32'h0);
    rd_chk("mask_data", mgm_pkg::OFS_MASK_DATA, 32'h0);
    rd_chk("gpio", mgm_pkg::OFS_GPIO_SEL, 32'h0);
    rd_chk("status", mgm_pkg::OFS_STATUS, 32'h06);
    wr(mgm_pkg::OFS_MASK_EN, 32'hffff_ffff);
    rd_chk("mask_en_w", mgm_pkg::OFS_MASK_EN, 32'h3f);
    wr(mgm_pkg::OFS_STATUS, 32'hffff_ffff);
    rd_chk("status_ro", mgm_pkg::OFS_STATUS, 32'h06);
    wr(8'h18, 32'hffff_ffff);
    rd_chk("unmapped", 8'h18, 32'h0);
    me = 6'h3f;
    // Hardware mask: every command with both PWM phases, all four side and complementary settings
    for (int k = 0; k < 4; k++) begin
      ctrl = {4'h0, k[1], 2'h0, k[0]};
      cfg();
      for (int i = 0; i < 128; i++) begin
        cmd <= i[5:0];
        pt <= i[6];
        pi <= ~i[6];
        gate_chk("hw_gates");
      end
      // Only A high on, so a swapped status field shows up
      cmd <= 6'h01;
      gate_chk("hw_a_high");
      e = exp_gates();
      rd_chk("status_g", mgm_pkg::OFS_STATUS,
             {26'h0, e[0], e[1], e[2], hall});
    end
    // Freeze: gates hold while the clock enable is low
    e = exp_gates();
    ce <= 1'b0;
    cmd <= 6'h2a;
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    `CHK("frozen", e, gates)
    @(posedge hclk);
    ce <= 1'b1;
    gate_chk("thawed");
    // Software mask: A drives 01, B 10, C 11
    cmd <= 6'h36;
    for (int s = 0; s < 6; s++) begin
      for (int i = 0; i < 64; i++) begin
        ctrl = {7'h40, s[0]};
        me = i[5:0];
        md = (s < 2) ? 6'h3f : (s < 4) ? 6'h15 : 6'h2a;
        cfg();
        pt <= i[0];
        pi <= ~i[0];
        gate_chk("sw_gates");
      end
    end
    // Brake, protection and general I/O over both mask modes
    me = 6'h0f;
    md = 6'h33;
    for (int i = 0; i < 64; i++) begin
      ctrl = {i[0], 5'h0, i[1], 1'b0};
      prot = i[3:2];
      gpio = i[5:3];
      cfg();
      gate_chk("override");
    end
    `CHK("shoot_through", exp_shorts, shorts)
    report_and_stop();
  end
endmodule : tb_top
